// File: rtl/link_status_pkg.sv
package link_status_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_LINK_NEG_STATUS = 8'h11;
    localparam logic [7:0] IDX_INT_STATUS = 8'h20;
    localparam logic [7:0] IDX_INT_MASK = 8'h21;
    localparam logic [11:0] ADDR_LINK_NEG_STATUS = 12'h044;
    localparam logic [11:0] ADDR_INT_STATUS = 12'h080;
    localparam logic [11:0] ADDR_INT_MASK = 12'h084;

    // Status field positions
    localparam int POL_HI = 15;
    localparam int POL_LO = 12;
    localparam int BIT_PWRDN = 11;
    localparam int BIT_XOVER = 10;
    localparam int BIT_FIFO_ERR = 9;
    localparam int BIT_RSVD8 = 8;
    localparam int BIT_SHALLOW_LB = 7;
    localparam int BIT_DEEP_LB = 6;
    localparam int BIT_NC_ONLY = 5;
    localparam int SPD_HI = 4;
    localparam int SPD_LO = 3;
    localparam int BIT_LINK = 2;
    localparam int BIT_DUPLEX = 1;
    localparam int BIT_MASTER = 0;

    // Speed codes
    localparam logic [1:0] SPD_10 = 2'h0;
    localparam logic [1:0] SPD_100 = 2'h1;
    localparam logic [1:0] SPD_1000 = 2'h2;
    localparam logic [1:0] SPD_RSVD = 2'h3;

    // Interrupt status bits
    localparam int INT_BITS = 4;
    localparam int IRQ_LINK_CHG = 0;
    localparam int IRQ_FIFO_ERR = 1;
    localparam int IRQ_POL_CHG = 2;
    localparam int IRQ_SPD_CHG = 3;

    // Reset values
    localparam logic [15:0] STATUS_RST = 16'h0000;
    localparam logic [INT_BITS-1:0] MASK_RST = 4'h0;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

endpackage

// File: rtl/link_negotiation_status.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Bits 15:12 show one reversed-polarity flag per pair A to D, 1 when reversed.
// - Reversed polarity is found and corrected inside, with no software action.
// - Bit 11 reads 1 while powered down; software writes it as 0.
// - Bit 10 reads 1 in crossover wiring and 0 in straight wiring.
// - Bit 9 is set by a transmit FIFO overflow or underrun, else reads 0.
// - The FIFO error flag is cleared whenever the link goes down.
// - Bit 7 reads 1 while shallow loopback is active.
// - Bit 6 reads 1 while deep loopback is active.
// - Bit 5 reads 1 when detecting only in non-compliant mode.
// - Bits 4:3 hold the speed as 10, 01 or 00, never 11.
// - Speed follows negotiation or manual setting and resets from the straps.
// - Bit 2 reads 1 while a good link is established.
// - Bit 1 reads 1 in full duplex and 0 in half duplex.
// - Bit 0 reads 1 while acting as master of gigabit timing.
// - Strap values change only when sampled at a reset, never by writes.
module link_negotiation_status
    import link_status_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Transceiver core state
    input wire logic [3:0] pair_polarity_raw,
    input wire logic power_down,
    input wire logic crossover_state,
    input wire logic tx_fifo_overflow,
    input wire logic tx_fifo_underrun,
    input wire logic shallow_loopback_en,
    input wire logic deep_loopback_en,
    input wire logic nc_only_detect,
    input wire logic autoneg_en,
    input wire logic autoneg_done,
    input wire logic [1:0] autoneg_speed,
    input wire logic [1:0] manual_speed,
    input wire logic link_good,
    input wire logic full_duplex,
    input wire logic gig_master,
    // Straps
    input wire logic [1:0] speed_strap,
    // Corrected pair polarity and interrupt
    output logic [3:0] pair_polarity_fix,
    output logic irq
);
    import link_status_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Status register
    logic [15:0] status_r;
    logic [15:0] status_nxt;
    logic [1:0] speed_nxt;
    logic strap_pending_r;
    logic link_prev_r;
    logic link_fall;

    assign link_fall = link_prev_r & ~link_good;

    always_comb begin
        if (autoneg_en) begin
            speed_nxt = autoneg_done ? autoneg_speed : status_r[SPD_HI:SPD_LO];
        end else begin
            speed_nxt = manual_speed;
        end
        if (speed_nxt == SPD_RSVD) begin
            speed_nxt = status_r[SPD_HI:SPD_LO];
        end
        status_nxt = STATUS_RST;
        status_nxt[POL_HI:POL_LO] = pair_polarity_raw;
        status_nxt[BIT_PWRDN] = power_down;
        status_nxt[BIT_XOVER] = crossover_state;
        if (link_fall) begin
            status_nxt[BIT_FIFO_ERR] = 1'b0;
        end else begin
            status_nxt[BIT_FIFO_ERR] = status_r[BIT_FIFO_ERR] | tx_fifo_overflow
                | tx_fifo_underrun;
        end
        status_nxt[BIT_RSVD8] = 1'b0;
        status_nxt[BIT_SHALLOW_LB] = shallow_loopback_en;
        status_nxt[BIT_DEEP_LB] = deep_loopback_en;
        status_nxt[BIT_NC_ONLY] = nc_only_detect;
        status_nxt[SPD_HI:SPD_LO] = speed_nxt;
        status_nxt[BIT_LINK] = link_good;
        status_nxt[BIT_DUPLEX] = full_duplex;
        status_nxt[BIT_MASTER] = gig_master;
    end

    // Strap sampled on the first edge after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= STATUS_RST;
            strap_pending_r <= 1'b1;
        end else if (strap_pending_r) begin
            status_r <= STATUS_RST;
            status_r[SPD_HI:SPD_LO] <= (speed_strap == SPD_RSVD) ? SPD_10 : speed_strap;
            strap_pending_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_prev_r <= 1'b0;
        end else begin
            link_prev_r <= link_good;
        end
    end

    // Internal polarity correction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pair_polarity_fix <= 4'h0;
        end else begin
            pair_polarity_fix <= pair_polarity_raw;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt events
    logic [INT_BITS-1:0] int_status_r;
    logic [INT_BITS-1:0] int_mask_r;
    logic [INT_BITS-1:0] event_vec;
    logic setup_ph;
    logic access_ph;
    logic rd_int;

    assign setup_ph = psel & ~penable;
    assign access_ph = psel & penable;
    assign rd_int = access_ph & ~pwrite & (paddr == ADDR_INT_STATUS);

    always_comb begin
        event_vec = '0;
        event_vec[IRQ_LINK_CHG] = ~strap_pending_r & (status_nxt[BIT_LINK] != status_r[BIT_LINK]);
        event_vec[IRQ_FIFO_ERR] = ~strap_pending_r & status_nxt[BIT_FIFO_ERR]
            & ~status_r[BIT_FIFO_ERR];
        event_vec[IRQ_POL_CHG] = ~strap_pending_r
            & (status_nxt[POL_HI:POL_LO] != status_r[POL_HI:POL_LO]);
        event_vec[IRQ_SPD_CHG] = ~strap_pending_r
            & (status_nxt[SPD_HI:SPD_LO] != status_r[SPD_HI:SPD_LO]);
    end

    // Read clears; a new event in the same cycle wins
    genvar gi;
    generate
        for (gi = 0; gi < INT_BITS; gi++) begin : g_int
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    int_status_r[gi] <= 1'b0;
                end else if (event_vec[gi]) begin
                    int_status_r[gi] <= 1'b1;
                end else if (rd_int) begin
                    int_status_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_mask_r <= MASK_RST;
        end else if (access_ph && pwrite && paddr == ADDR_INT_MASK && pstrb[0]) begin
            int_mask_r <= pwdata[INT_BITS-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_status_r & int_mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave: no wait states, data registered in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup_ph;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= RDATA_ZERO;
            pslverr <= 1'b0;
        end else if (setup_ph) begin
            prdata <= RDATA_ZERO;
            pslverr <= 1'b0;
            case (paddr)
                ADDR_LINK_NEG_STATUS: begin
                    if (!pwrite) begin
                        prdata[15:0] <= status_r;
                    end
                end
                ADDR_INT_STATUS: begin
                    if (!pwrite) begin
                        prdata[INT_BITS-1:0] <= int_status_r | event_vec;
                    end
                end
                ADDR_INT_MASK: begin
                    if (!pwrite) begin
                        prdata[INT_BITS-1:0] <= int_mask_r;
                    end
                end
                default: begin
                    pslverr <= 1'b1;
                end
            endcase
        end else begin
            pslverr <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_fifo_clr;
        @(posedge pclk) disable iff (!presetn)
        (link_fall && !strap_pending_r) |=> !status_r[BIT_FIFO_ERR];
    endproperty
    a_fifo_clr: assert property (p_fifo_clr) else $error("fifo error not cleared");

    property p_fifo_set;
        @(posedge pclk) disable iff (!presetn)
        (tx_fifo_overflow && !link_fall && !strap_pending_r) |=> status_r[BIT_FIFO_ERR];
    endproperty
    a_fifo_set: assert property (p_fifo_set) else $error("fifo error not set");

    property p_spd_legal;
        @(posedge pclk) disable iff (!presetn)
        status_r[SPD_HI:SPD_LO] != SPD_RSVD;
    endproperty
    a_spd_legal: assert property (p_spd_legal) else $error("reserved speed code");

    property p_link;
        @(posedge pclk) disable iff (!presetn)
        !strap_pending_r |=> status_r[BIT_LINK] == $past(link_good);
    endproperty
    a_link: assert property (p_link) else $error("link bit mismatch");

    property p_pol;
        @(posedge pclk) disable iff (!presetn)
        !strap_pending_r |=> status_r[POL_HI:POL_LO] == $past(pair_polarity_raw);
    endproperty
    a_pol: assert property (p_pol) else $error("polarity mismatch");

    property p_rsvd;
        @(posedge pclk) disable iff (!presetn)
        !status_r[BIT_RSVD8];
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("bit 8 set");

    property p_ro;
        @(posedge pclk) disable iff (!presetn)
        (access_ph && pwrite && paddr == ADDR_LINK_NEG_STATUS && !strap_pending_r)
            |=> status_r == $past(status_nxt);
    endproperty
    a_ro: assert property (p_ro) else $error("write altered status");

    property p_manual_spd;
        @(posedge pclk) disable iff (!presetn)
        (!autoneg_en && manual_speed != SPD_RSVD && !strap_pending_r)
            |=> status_r[SPD_HI:SPD_LO] == $past(manual_speed);
    endproperty
    a_manual_spd: assert property (p_manual_spd) else $error("manual speed lost");

    property p_xover;
        @(posedge pclk) disable iff (!presetn)
        !strap_pending_r |=> status_r[BIT_XOVER] == $past(crossover_state);
    endproperty
    a_xover: assert property (p_xover) else $error("crossover mismatch");

    property p_pwrdn;
        @(posedge pclk) disable iff (!presetn)
        !strap_pending_r |=> status_r[BIT_PWRDN] == $past(power_down);
    endproperty
    a_pwrdn: assert property (p_pwrdn) else $error("power down mismatch");

    property p_shallow;
        @(posedge pclk) disable iff (!presetn)
        !strap_pending_r |=> status_r[BIT_SHALLOW_LB] == $past(shallow_loopback_en);
    endproperty
    a_shallow: assert property (p_shallow) else $error("shallow loopback mismatch");

    property p_deep;
        @(posedge pclk) disable iff (!presetn)
        !strap_pending_r |=> status_r[BIT_DEEP_LB] == $past(deep_loopback_en);
    endproperty
    a_deep: assert property (p_deep) else $error("deep loopback mismatch");

    property p_nc_only;
        @(posedge pclk) disable iff (!presetn)
        !strap_pending_r |=> status_r[BIT_NC_ONLY] == $past(nc_only_detect);
    endproperty
    a_nc_only: assert property (p_nc_only) else $error("non compliant mismatch");

    property p_duplex;
        @(posedge pclk) disable iff (!presetn)
        !strap_pending_r |=> status_r[BIT_DUPLEX] == $past(full_duplex);
    endproperty
    a_duplex: assert property (p_duplex) else $error("duplex mismatch");

    property p_master;
        @(posedge pclk) disable iff (!presetn)
        !strap_pending_r |=> status_r[BIT_MASTER] == $past(gig_master);
    endproperty
    a_master: assert property (p_master) else $error("master bit mismatch");

    property p_pol_fix;
        @(posedge pclk) disable iff (!presetn)
        !strap_pending_r |=> pair_polarity_fix == $past(pair_polarity_raw);
    endproperty
    a_pol_fix: assert property (p_pol_fix) else $error("polarity not corrected");

    property p_fifo_under;
        @(posedge pclk) disable iff (!presetn)
        (tx_fifo_underrun && !link_fall && !strap_pending_r) |=> status_r[BIT_FIFO_ERR];
    endproperty
    a_fifo_under: assert property (p_fifo_under) else $error("fifo underrun not set");

    property p_fifo_hold;
        @(posedge pclk) disable iff (!presetn)
        (!tx_fifo_overflow && !tx_fifo_underrun && !link_fall && !strap_pending_r)
            |=> $stable(status_r[BIT_FIFO_ERR]);
    endproperty
    a_fifo_hold: assert property (p_fifo_hold) else $error("fifo error changed");

    property p_auto_spd;
        @(posedge pclk) disable iff (!presetn)
        (autoneg_en && autoneg_done && autoneg_speed != SPD_RSVD && !strap_pending_r)
            |=> status_r[SPD_HI:SPD_LO] == $past(autoneg_speed);
    endproperty
    a_auto_spd: assert property (p_auto_spd) else $error("negotiated speed lost");

    property p_spd_hold;
        @(posedge pclk) disable iff (!presetn)
        (autoneg_en && !autoneg_done && !strap_pending_r)
            |=> $stable(status_r[SPD_HI:SPD_LO]);
    endproperty
    a_spd_hold: assert property (p_spd_hold) else $error("speed moved");

    property p_strap_load;
        @(posedge pclk) disable iff (!presetn)
        (strap_pending_r && presetn)
            |=> status_r[SPD_HI:SPD_LO]
                == (($past(speed_strap) == SPD_RSVD) ? SPD_10 : $past(speed_strap));
    endproperty
    a_strap_load: assert property (p_strap_load) else $error("strap speed wrong");

    property p_rst_zero;
        @(posedge pclk) disable iff (!presetn)
        (strap_pending_r && presetn)
            |=> status_r[POL_HI:SPD_HI+1] == 11'h000 && status_r[BIT_LINK:BIT_MASTER] == 3'h0;
    endproperty
    a_rst_zero: assert property (p_rst_zero) else $error("status not zero after reset");

    property p_rd_status;
        @(posedge pclk) disable iff (!presetn)
        (setup_ph && !pwrite && paddr == ADDR_LINK_NEG_STATUS)
            |=> prdata == {16'h0000, $past(status_r)};
    endproperty
    a_rd_status: assert property (p_rd_status) else $error("status read data wrong");

endmodule
`default_nettype wire

// File: dv/mgmt_model.sv
`timescale 1ns/1ps
`default_nettype none
module mgmt_model (
    // Clock
    input wire logic pclk,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // One transfer, entered just after a rising edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic err);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d & 32'hFFFF_FEFF;
        pstrb <= 4'hF;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata & 32'hFFFF_FEFF;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// File: dv/link_negotiation_status_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
    $display("mismatch at %0t: %h vs %h", $time, (a), (b)); end end
module link_negotiation_status_test;
    import link_status_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, irq, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] pstrb, pair_polarity_raw = 4'h0, pair_polarity_fix;
    logic power_down = 0, crossover_state = 0, tx_fifo_overflow = 0, tx_fifo_underrun = 0;
    logic shallow_loopback_en = 0, deep_loopback_en = 0, nc_only_detect = 0, autoneg_en = 1;
    logic autoneg_done = 0, link_good = 0, full_duplex = 0, gig_master = 0;
    logic [1:0] autoneg_speed = 2'h0, manual_speed = 2'h0, speed_strap = 2'h2;
    logic [15:0] m = 16'hFCE7;
    int fails = 0, checks_done = 0, cyc = 0;
    always #5 pclk = ~pclk;
    link_negotiation_status link_negotiation_status_i (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .pair_polarity_raw,
        .power_down, .crossover_state, .tx_fifo_overflow, .tx_fifo_underrun,
        .shallow_loopback_en, .deep_loopback_en, .nc_only_detect, .autoneg_en, .autoneg_done,
        .autoneg_speed, .manual_speed, .link_good, .full_duplex, .gig_master, .speed_strap,
        .pair_polarity_fix, .irq);
    mgmt_model mgmt_model_i (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            finish_test();
        end
    end
    task automatic rd(input logic [11:0] a);
        mgmt_model_i.xfer(1'b0, a, 32'h0000_0000, q, e);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        mgmt_model_i.xfer(1'b1, a, d, q, e);
    endtask
    task automatic set_core(input logic [15:0] w);
        pair_polarity_raw <= w[15:12];
        power_down <= w[11];
        crossover_state <= w[10];
        shallow_loopback_en <= w[7];
        deep_loopback_en <= w[6];
        nc_only_detect <= w[5];
        link_good <= w[2];
        full_duplex <= w[1];
        gig_master <= w[0];
        repeat (3) @(posedge pclk);
    endtask
    task automatic pulse_fifo(input logic u);
        tx_fifo_overflow <= !u;
        tx_fifo_underrun <= u;
        @(posedge pclk);
        tx_fifo_overflow <= 1'b0;
        tx_fifo_underrun <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        rd(ADDR_LINK_NEG_STATUS);
        `CHK(q, 32'h0000_0010)
        rd(ADDR_INT_MASK);
        `CHK(q, 32'h0000_0000)
        speed_strap <= 2'h1;
        wr(ADDR_LINK_NEG_STATUS, 32'h0000_FEFF);
        rd(ADDR_LINK_NEG_STATUS);
        `CHK(q, 32'h0000_0010)
        for (int i = 0; i < 16; i++) begin
            if (m[i]) begin
                set_core(16'h0001 << i);
                rd(ADDR_LINK_NEG_STATUS);
                `CHK(q, {16'h0000, 16'h0001 << i | 16'h0010})
                `CHK(pair_polarity_fix, pair_polarity_raw)
            end
        end
        set_core(16'h0000);
        rd(ADDR_INT_STATUS);
        `CHK(q, 32'h0000_0005)
        wr(ADDR_INT_MASK, 32'h0000_0001);
        rd(ADDR_INT_MASK);
        `CHK(q, 32'h0000_0001)
        `CHK(irq, 1'b0)
        set_core(16'h0004);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b1)
        rd(ADDR_INT_STATUS);
        `CHK(q, 32'h0000_0001)
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b0)
        pulse_fifo(1'b0);
        rd(ADDR_LINK_NEG_STATUS);
        `CHK(q, 32'h0000_0214)
        `CHK(irq, 1'b0)
        set_core(16'h0000);
        rd(ADDR_LINK_NEG_STATUS);
        `CHK(q, 32'h0000_0010)
        set_core(16'h0004);
        pulse_fifo(1'b1);
        rd(ADDR_LINK_NEG_STATUS);
        `CHK(q, 32'h0000_0214)
        set_core(16'h0000);
        autoneg_done <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            autoneg_speed <= 2'(s);
            repeat (3) @(posedge pclk);
            rd(ADDR_LINK_NEG_STATUS);
            `CHK(q[4:3], (s == 3) ? 2'h2 : 2'(s))
        end
        autoneg_en <= 1'b0;
        manual_speed <= 2'h1;
        repeat (3) @(posedge pclk);
        rd(ADDR_LINK_NEG_STATUS);
        `CHK(q[4:3], 2'h1)
        rd(ADDR_INT_STATUS);
        `CHK(q, 32'h0000_000B)
        rd(12'h0FC);
        `CHK(e, 1'b1)
        rd(ADDR_INT_MASK);
        `CHK(e, 1'b0)
        presetn <= 1'b0;
        speed_strap <= 2'h3;
        autoneg_en <= 1'b1;
        autoneg_done <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        rd(ADDR_LINK_NEG_STATUS);
        `CHK(q, 32'h0000_0000)
        finish_test();
    end
endmodule
`default_nettype wire
